/* File: core/fsr_pkg.sv */
// Package for the flowmeter status and time register slice
package fsr_pkg;
  // Register addresses (non-compatible word addressing)
  localparam logic [15:0] ADDR_PATH6_ALARM  = 16'h138f;
  localparam logic [15:0] ADDR_INPUT_ALARM  = 16'h1390;
  localparam logic [15:0] ADDR_TOTAL_STATUS = 16'h1391;
  localparam logic [15:0] ADDR_LOOPBACK     = 16'h157c;
  localparam logic [15:0] ADDR_EPOCH        = 16'h157d;
  // Holding range bounds, inclusive
  localparam logic [15:0] HOLD_LO           = 16'h157c;
  localparam logic [15:0] HOLD_HI           = 16'h176f;
  // Field positions
  localparam int BIT_SIGNAL_MISSING = 3;
  localparam int BIT_TEMP_OOR       = 0;
  localparam int BIT_TEMP_SUBST     = 1;
  localparam int BIT_FWD_WRAP       = 1;
  localparam int BIT_REV_WRAP       = 5;
  localparam int BIT_FAIL_FWD_WRAP  = 9;
  localparam int BIT_FAIL_REV_WRAP  = 13;
  // Override mode encodings
  localparam logic [1:0] OVR_MODE_OFF   = 2'h0;
  localparam logic [1:0] OVR_MODE_ONE   = 2'h1;
  localparam logic [1:0] OVR_MODE_TWO   = 2'h2;
  localparam logic [1:0] OVR_MODE_THREE = 2'h3;
  // Reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [15:0] RST_HALF = 16'h0000;
  // Clock rate and one-second tick
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned SEC_S  = 1;
  localparam int unsigned TICKS_PER_SEC = CLK_HZ * SEC_S;
  // Register access from the serial protocol engine, one 16-bit half per access
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic        hi_half;
    logic [15:0] wdata;
  } fsr_req_t;
  // Totaliser index
  typedef enum logic [1:0] {
    FSR_TOT_FWD      = 2'h0,
    FSR_TOT_REV      = 2'h1,
    FSR_TOT_FAIL_FWD = 2'h3,
    FSR_TOT_FAIL_REV = 2'h2
  } fsr_tot_t;
endpackage

/* File: core/fsr_regs.sv */
// Status, totaliser, loopback and clock register slice of the flowmeter map
//
// Functional notes
// - Path six signal lost sets bit 3
// - Temp override alarm when enabled, mode 1/2
// - Mode 3 override raises no alarm
// - Totaliser wraps to zero, sets rollover bit
// - Rollover bits at 1, 5, 9, 13
// - Loopback test word stored, read back
// - Epoch seconds counter from real-time clock
// - Bus writes to epoch seconds ignored
// - Holding values accessed as two halves
module fsr_regs #(
  parameter int unsigned TOT_W         = 32,
  parameter int unsigned TICKS_PER_SEC = fsr_pkg::TICKS_PER_SEC
) (
  // Clock and asynchronous reset
  input  wire logic                ref_clk,
  input  wire logic                resetn,
  // Register access, one 16-bit half per request
  input  wire fsr_pkg::fsr_req_t   bus_req,
  // Answer to each request, one cycle later
  output logic [15:0]              bus_rdata,
  output logic                     bus_rvalid,
  output logic                     bus_err,
  // Alarm causes from the measurement side, not on this clock
  input  wire logic                path_signal_missing_flag,
  input  wire logic                temp_out_of_range_flag,
  input  wire logic                temp_manual_in_use,
  // Alarm parameter and override selection, on this clock
  input  wire logic                temp_subst_alarm_enable,
  input  wire logic [1:0]          temp_override_mode,
  // Totaliser steps and rollover flag clears
  input  wire logic [3:0]          tot_inc_valid,
  input  wire logic [4*TOT_W-1:0]  tot_inc,
  input  wire logic [3:0]          tot_wrap_clear,
  // Configuration path that sets the real-time clock
  input  wire logic                clock_set,
  input  wire logic [31:0]         clock_set_value,
  // Running totals and clock seconds for the rest of the meter
  output logic [4*TOT_W-1:0]       tot_value,
  output logic [31:0]              epoch_seconds
);

  // Two-stage synchronisers for the pin-level alarm inputs
  // Bit 0 signal lost, bit 1 out of range, bit 2 manual value in use
  logic [2:0] sync_a;        // First stage, may go metastable
  logic [2:0] sync_b;        // Second stage, the only one logic reads
  logic [2:0] next_sync_a;
  logic [2:0] next_sync_b;
  logic       sig_missing;   // Synchronised signal-lost level
  logic       temp_oor;      // Synchronised out-of-range level
  logic       temp_manual;   // Synchronised manual-value-in-use level

  // Next values of both stages: the first takes the pins,
  // the second takes the first; nothing else reads stage one
  always_comb
  begin
    // Pins packed in the same order as the taps below
    next_sync_a = {temp_manual_in_use, temp_out_of_range_flag, path_signal_missing_flag};
    next_sync_b = sync_a;
  end

  // Both stages clear on reset, so no false alarm follows it
  // Levels only: a glitch shorter than a cycle may be missed
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sync_a <= '0;
      sync_b <= '0;
    end
    else
    begin
      sync_a <= next_sync_a;
      sync_b <= next_sync_b;
    end
  end

  // Named taps on the second stage
  assign sig_missing = sync_b[0];
  assign temp_oor    = sync_b[1];
  assign temp_manual = sync_b[2];

  // Status words as seen from the bus
  // Only the alarm bits are live; the rest of each word reads zero
  logic [31:0] path6_alarm_status;         // Path six alarm word
  logic [31:0] input_alarm_flags;          // Temperature alarm word
  logic [31:0] totaliser_rollover_status;  // Rollover flags in place
  // Next values of the two alarm words
  logic [31:0] next_path6;
  logic [31:0] next_inputs;

  // Alarm words follow their causes, so they are levels, not sticky
  // A master that needs a latched alarm must poll faster than the cause
  always_comb
  begin
    // Unused bits stay zero
    next_path6  = fsr_pkg::RST_WORD;
    next_inputs = fsr_pkg::RST_WORD;
    // Path six: signal lost while the cause stands
    next_path6[fsr_pkg::BIT_SIGNAL_MISSING] = sig_missing;
    // Out-of-range follows the measured temperature
    next_inputs[fsr_pkg::BIT_TEMP_OOR] = temp_oor;
    // Only modes one and two alarm; mode three stays silent
    // Mode zero means no override, so it is silent as well
    next_inputs[fsr_pkg::BIT_TEMP_SUBST] = temp_manual && temp_subst_alarm_enable &&
      ((temp_override_mode == fsr_pkg::OVR_MODE_ONE) ||
       (temp_override_mode == fsr_pkg::OVR_MODE_TWO));
  end

  // Register the words so a read sees one settled value
  // The flags lag their causes by one more cycle as a result
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      path6_alarm_status <= fsr_pkg::RST_WORD;
      input_alarm_flags  <= fsr_pkg::RST_WORD;
    end
    else
    begin
      path6_alarm_status <= next_path6;
      input_alarm_flags  <= next_inputs;
    end
  end

  // Totalisers: wrap to zero past the top, keep the remainder
  // Index 0 forward, 1 reverse, 3 failure forward, 2 failure reverse
  // A step larger than the headroom still wraps once and keeps the rest
  logic [4*TOT_W-1:0] next_tot;   // Next value of all four totals
  logic [3:0]         wrap;       // Sticky rollover flags
  logic [3:0]         next_wrap;  // Next rollover flags

  always_comb
  begin
    logic [TOT_W:0] sum;
    // Defaults: totals and flags hold
    sum       = '0;
    next_tot  = tot_value;
    next_wrap = wrap;
    // Four totalisers handled alike
    for (int i = 0; i < 4; i++)
    begin
      // One extra bit catches the carry out of the top
      sum = {1'b0, tot_value[i*TOT_W +: TOT_W]} + {1'b0, tot_inc[i*TOT_W +: TOT_W]};
      // Clear first so a wrap in the same cycle wins
      if (tot_wrap_clear[i])
        next_wrap[i] = 1'b0;
      // A step without valid leaves the total alone
      if (tot_inc_valid[i])
      begin
        next_tot[i*TOT_W +: TOT_W] = sum[TOT_W-1:0];
        if (sum[TOT_W])
          next_wrap[i] = 1'b1;
      end
    end
  end

  // Totals and sticky rollover flags; a flag stays until cleared
  // Totals restart from zero on reset, like a fresh meter
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      tot_value <= '0;
      wrap      <= '0;
    end
    else
    begin
      tot_value <= next_tot;
      wrap      <= next_wrap;
    end
  end

  // Rollover bits placed at their fixed positions
  // Pure wiring: unused bits read as zero
  // Flags are kept in totaliser order and spread out here
  always_comb
  begin
    totaliser_rollover_status = fsr_pkg::RST_WORD;
    totaliser_rollover_status[fsr_pkg::BIT_FWD_WRAP]      = wrap[fsr_pkg::FSR_TOT_FWD];
    totaliser_rollover_status[fsr_pkg::BIT_REV_WRAP]      = wrap[fsr_pkg::FSR_TOT_REV];
    totaliser_rollover_status[fsr_pkg::BIT_FAIL_FWD_WRAP] = wrap[fsr_pkg::FSR_TOT_FAIL_FWD];
    totaliser_rollover_status[fsr_pkg::BIT_FAIL_REV_WRAP] = wrap[fsr_pkg::FSR_TOT_FAIL_REV];
  end

  // Real-time clock: prescaler and seconds counter
  // Prescaler counts clock cycles up to one second
  logic [31:0] prescale;       // Cycles into the current second
  logic [31:0] next_prescale;  // Next prescaler count
  logic [31:0] next_epoch;     // Next seconds count

  always_comb
  begin
    // Default: count on, seconds hold
    next_prescale = prescale + 32'h1;
    next_epoch    = epoch_seconds;
    // One second has passed once the prescaler reaches its top
    // The top comes from a parameter so a bench may shorten it
    if (prescale == 32'(TICKS_PER_SEC - 1))
    begin
      next_prescale = 32'h0;
      next_epoch    = epoch_seconds + 32'h1;
    end
    // Only the configuration path sets the clock, never the bus
    // A load also restarts the prescaler, so the first second is whole
    if (clock_set)
    begin
      next_prescale = 32'h0;
      next_epoch    = clock_set_value;
    end
  end

  // Seconds start from zero on reset until the clock is set
  // No calendar here: the count wraps once its 32 bits are used up
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      prescale      <= fsr_pkg::RST_WORD;
      epoch_seconds <= fsr_pkg::RST_WORD;
    end
    else
    begin
      prescale      <= next_prescale;
      epoch_seconds <= next_epoch;
    end
  end

  // Loopback word and bus answer
  // The loopback word touches nothing else in the meter
  // Unmapped reads and stray writes are refused with an error pulse
  logic [31:0] loopback_test_word;  // Stored test word
  logic [31:0] next_loop;           // Next test word
  logic [15:0] next_rdata;          // Next read half
  logic        next_rvalid;         // Next answer strobe
  logic        next_err;            // Next refusal flag

  // Everything the bus sees is computed here in one pass
  always_comb
  begin
    logic [31:0] word;
    logic        hit;
    word        = fsr_pkg::RST_WORD;
    hit         = 1'b1;
    // Defaults: no answer, loopback word kept
    next_loop   = loopback_test_word;
    next_rdata  = fsr_pkg::RST_HALF;
    next_rvalid = 1'b0;
    next_err    = 1'b0;
    // Decode the address for reads; writes compare it again below
    case (bus_req.addr)
      fsr_pkg::ADDR_PATH6_ALARM:  word = path6_alarm_status;
      fsr_pkg::ADDR_INPUT_ALARM:  word = input_alarm_flags;
      fsr_pkg::ADDR_TOTAL_STATUS: word = totaliser_rollover_status;
      fsr_pkg::ADDR_LOOPBACK:     word = loopback_test_word;
      fsr_pkg::ADDR_EPOCH:        word = epoch_seconds;
      default:                    hit  = 1'b0;
    endcase
    // A read wins if a request carries both strobes
    if (bus_req.rd)
    begin
      next_rvalid = 1'b1;
      // An unmapped read returns zero data with the error
      next_err    = !hit;
      // Each value is served as its high or low half
      next_rdata  = bus_req.hi_half ? word[31:16] : word[15:0];
    end
    // Writes are answered too, so the master sees every request land
    else if (bus_req.wr)
    begin
      next_rvalid = 1'b1;
      // Only the loopback word stores write data
      if (bus_req.addr == fsr_pkg::ADDR_LOOPBACK)
      begin
        // Each half of the loopback word is written on its own
        if (bus_req.hi_half)
          next_loop[31:16] = bus_req.wdata;
        else
          next_loop[15:0] = bus_req.wdata;
      end
      // Epoch and rest of holding range take writes silently
      else if (!((bus_req.addr >= fsr_pkg::HOLD_LO) && (bus_req.addr <= fsr_pkg::HOLD_HI)))
        next_err = 1'b1;
    end
  end

  // Answer registers: each answer stands for exactly one cycle
  // Read data drops back to zero between answers
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      loopback_test_word <= fsr_pkg::RST_WORD;
      bus_rdata          <= fsr_pkg::RST_HALF;
      bus_rvalid         <= 1'b0;
      bus_err            <= 1'b0;
    end
    else
    begin
      loopback_test_word <= next_loop;
      bus_rdata          <= next_rdata;
      bus_rvalid         <= next_rvalid;
      bus_err            <= next_err;
    end
  end

endmodule

/* File: verification/fsr_sva.sv */
// Port checker for the status and time register slice
module fsr_sva (
  input wire logic              ref_clk,
  input wire logic              resetn,
  input wire fsr_pkg::fsr_req_t bus_req,
  input wire logic [15:0]       bus_rdata,
  input wire logic              bus_rvalid,
  input wire logic              bus_err,
  input wire logic [1:0]        temp_override_mode,
  input wire logic              clock_set,
  input wire logic [31:0]       clock_set_value,
  input wire logic [31:0]       epoch_seconds
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  a_answer_next: assert property ((bus_req.rd || bus_req.wr) |=> bus_rvalid)
    else $error("access not answered next cycle");
  a_no_extra: assert property (!(bus_req.rd || bus_req.wr) |=> !bus_rvalid && !bus_err)
    else $error("answer without access");
  a_idle_data: assert property (!bus_rvalid |-> bus_rdata == 16'h0)
    else $error("read data not zero when idle");
  a_unmapped_err: assert property (bus_req.rd && bus_req.addr == 16'h1392 |=> bus_err && bus_rdata == 16'h0)
    else $error("unmapped read not refused");
  a_hold_quiet: assert property (bus_req.wr && !bus_req.rd &&
    bus_req.addr inside {[fsr_pkg::HOLD_LO:fsr_pkg::HOLD_HI]} |=> !bus_err) else $error("holding write refused");
  a_mode3_quiet: assert property (bus_req.rd && bus_req.addr == fsr_pkg::ADDR_INPUT_ALARM &&
    !bus_req.hi_half && temp_override_mode == 2'h3 && $past(temp_override_mode) == 2'h3 |=> !bus_rdata[1])
    else $error("mode three raised override alarm");
  a_clock_load: assert property (clock_set |=> epoch_seconds == $past(clock_set_value))
    else $error("clock load lost");
  a_epoch_step: assert property (!$past(clock_set) && epoch_seconds != $past(epoch_seconds)
    |-> epoch_seconds == $past(epoch_seconds) + 32'h1) else $error("seconds jumped");
endmodule
bind fsr_regs fsr_sva u_fsr_sva (.ref_clk, .resetn, .bus_req, .bus_rdata, .bus_rvalid, .bus_err,
  .temp_override_mode, .clock_set, .clock_set_value, .epoch_seconds);

/* File: verification/fsr_master.sv */
// Remote bus master model: each value as two 16-bit accesses
module fsr_master (
  input  wire logic        ref_clk,
  output fsr_pkg::fsr_req_t bus_req,
  input  wire logic [15:0] bus_rdata,
  input  wire logic        bus_rvalid,
  input  wire logic        bus_err
);
  timeunit 1ns;
  timeprecision 1ns;
  initial bus_req = '0;
  // One half: driven after the first edge, taken at the next, answer read just after that edge
  task automatic acc(input logic w, input logic [15:0] a, input logic h, input logic [15:0] d,
                     output logic [15:0] q, output logic [1:0] st);
    @(posedge ref_clk) #1 bus_req = {!w, w, a, h, d};
    @(posedge ref_clk) #1 bus_req = '0;
    q = bus_rdata;
    st = {bus_rvalid, bus_err};
  endtask
  // Low half first, then high; status of both halves merged
  task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic [1:0] st);
    logic [1:0] s0;
    acc(w, a, 1'b0, d[15:0], q[15:0], s0);
    acc(w, a, 1'b1, d[31:16], q[31:16], st);
    st = {st[1] & s0[1], st[0] | s0[0]};
  endtask
endmodule

/* File: verification/fsr_regs_tb_top.sv */
// Testbench top for the status and time register slice
module fsr_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 0, resetn = 0, lost = 0, oor = 0, man = 0, en = 0, cs = 0;
  logic [1:0] mode = 0;
  logic [3:0] tv = 0, tc = 0;
  logic [127:0] ti = 0, tot;
  logic [31:0] csv = 0, ep;
  fsr_pkg::fsr_req_t bus_req;
  logic [15:0] rdata;
  logic rvalid, err;
  int failures = 0, checks_done = 0;
  localparam int unsigned TICKS = 4; // Short second keeps the clock test brief
  always #25 ref_clk = ~ref_clk;
  fsr_regs #(.TOT_W(32), .TICKS_PER_SEC(TICKS)) u_fsr_regs (.ref_clk, .resetn, .bus_req, .bus_rdata(rdata),
    .bus_rvalid(rvalid), .bus_err(err), .path_signal_missing_flag(lost), .temp_out_of_range_flag(oor),
    .temp_manual_in_use(man), .temp_subst_alarm_enable(en), .temp_override_mode(mode), .tot_inc_valid(tv),
    .tot_inc(ti), .tot_wrap_clear(tc), .clock_set(cs), .clock_set_value(csv), .tot_value(tot), .epoch_seconds(ep));
  fsr_master u_fsr_master (.ref_clk, .bus_req, .bus_rdata(rdata), .bus_rvalid(rvalid), .bus_err(err));
  // Compare and count
  task chk(input logic [33:0] g, input logic [33:0] e);
    checks_done++;
    if (g !== e)
    begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Whole-value access; write data is not compared
  task rx(input logic w, input logic [15:0] a, input logic [31:0] d, input logic [31:0] x, input logic e);
    logic [31:0] q;
    logic [1:0] st;
    u_fsr_master.xfer(w, a, d, q, st);
    chk({w ? 32'h0 : q, st}, {x, 1'b1, e});
  endtask
  task end_of_test;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Hang guard, well above the run length
  initial
  begin
    #1ms failures++;
    end_of_test;
  end
  initial
  begin
    logic [31:0] xs;
    logic [31:0] q;
    logic [1:0] st;
    int b[4] = '{1, 5, 13, 9};
    xs = 0;
    repeat (3) @(posedge ref_clk);
    #1 resetn = 1;
    rx(0, fsr_pkg::ADDR_PATH6_ALARM, 0, 0, 0);
    lost = 1;
    oor = 1;
    man = 1;
    repeat (4) @(posedge ref_clk);
    #1 rx(0, fsr_pkg::ADDR_PATH6_ALARM, 0, 32'h8, 0);
    // Every override mode enabled, then mode one disabled
    for (int i = 0; i < 5; i++)
    begin
      en = i < 4;
      mode = (i == 4) ? 2'h1 : 2'(i);
      rx(0, fsr_pkg::ADDR_INPUT_ALARM, 0, {30'h0, en && (mode == 1 || mode == 2), 1'b1}, 0);
    end
    // Causes gone: both alarm words clear again
    lost = 0;
    oor = 0;
    repeat (4) @(posedge ref_clk);
    #1 rx(0, fsr_pkg::ADDR_INPUT_ALARM, 0, 0, 0);
    rx(0, fsr_pkg::ADDR_PATH6_ALARM, 0, 0, 0);
    // Each totaliser: top value, then a step that carries out
    for (int k = 0; k < 4; k++)
    begin
      ti = 0;
      ti[k*32 +: 32] = 32'hffff_ffff;
      tv = 4'h1 << k;
      @(posedge ref_clk) #1 ti[k*32 +: 32] = 32'h2;
      @(posedge ref_clk) #1 tv = 0;
      chk(tot[k*32 +: 32], 1);
      xs[b[k]] = 1;
      rx(0, fsr_pkg::ADDR_TOTAL_STATUS, 0, xs, 0);
    end
    tc = 4'hf;
    @(posedge ref_clk) #1 tc = 0;
    rx(0, fsr_pkg::ADDR_TOTAL_STATUS, 0, 0, 0);
    rx(1, fsr_pkg::ADDR_LOOPBACK, 32'ha5c3_0f1e, 0, 0);
    rx(0, fsr_pkg::ADDR_LOOPBACK, 0, 32'ha5c3_0f1e, 0);
    csv = 32'h1234_5678;
    cs = 1;
    @(posedge ref_clk) #1 cs = 0;
    chk(ep, csv);
    repeat (TICKS) @(posedge ref_clk);
    #1 chk(ep, csv + 32'h1);
    rx(1, fsr_pkg::ADDR_EPOCH, 0, 0, 0);
    u_fsr_master.xfer(0, fsr_pkg::ADDR_EPOCH, 0, q, st);
    chk(q - csv < 5, 1);
    rx(0, 16'h1392, 0, 0, 1);
    rx(1, fsr_pkg::ADDR_PATH6_ALARM, 1, 0, 1);
    rx(1, fsr_pkg::HOLD_HI, 1, 0, 0);
    rx(1, fsr_pkg::HOLD_HI + 16'h1, 1, 0, 1);
    rx(0, fsr_pkg::ADDR_LOOPBACK, 0, 32'ha5c3_0f1e, 0);
    end_of_test;
  end
endmodule
